// ### hdl/offset_chain_pkg.sv
package offset_chain_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned SAMPLE_W = 26;
	localparam int unsigned FRAC_W = 24;
	localparam int unsigned GAIN_W = 24;
	localparam int unsigned ACC_W = SAMPLE_W + FRAC_W;
	localparam int unsigned PDCM_SHORT_W = 10;
	localparam int unsigned PDCM_LONG_W = 14;
	localparam int unsigned RESULT_W = 16;
	localparam int unsigned SUBSTEPS = 16;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned PHASE1_MS = 80;
	localparam int unsigned PHASE2_MS = 70;
	localparam int unsigned MON_DELAY_MS = 2100;
	localparam int unsigned RATE_INTERVAL_US = 1000;
	localparam int unsigned SUBSTEP_NS = 1000;
	localparam int unsigned PHASE1_CYC = PHASE1_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned PHASE2_CYC = PHASE2_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned MON_DELAY_CYC = MON_DELAY_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned RATE_INTERVAL_CYC = RATE_INTERVAL_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SUBSTEP_CYC = SUBSTEP_NS / CLK_PERIOD_NS;

	// ****************************************
	// offset filter gains, 24 fraction bits
	// ****************************************
	localparam logic [GAIN_W-1:0] GAIN_10HZ = 24'h0415C1;
	localparam logic [GAIN_W-1:0] GAIN_1HZ = 24'h006954;
	localparam logic [GAIN_W-1:0] GAIN_0P1HZ = 24'h000A8A;

	// ****************************************
	// filter select field layout
	// ****************************************
	localparam int unsigned SEL_RATE_BIT = 2;
	localparam logic [1:0] SEL_CORNER_10HZ = 2'h0;
	localparam logic [1:0] SEL_CORNER_1HZ = 2'h1;

	// ****************************************
	// defaults
	// ****************************************
	localparam int unsigned RATE_STEP_DEF = 1;
	localparam int unsigned MON_CNT_W_DEF = 8;
	localparam int unsigned MON_THRESHOLD_DEF = 100;
	localparam logic [RESULT_W-1:0] RESULT_BIAS = 16'h8000;

	typedef enum logic [2:0] {
		PH_FAST = 3'b001,
		PH_SLOW = 3'b010,
		PH_DONE = 3'b100
	} startup_t;
endpackage : offset_chain_pkg

// ### hdl/offset_chain.sv
// How it works
// R1: offset cancellation can be switched on or off and removes internal offset
// R2: offset estimate is a first-order IIR low-pass with 10, 1.0, 0.1 Hz gains
// R3: startup runs 80 ms at 10 Hz, then 70 ms at 1.0 Hz, no rate limit
// R4: after startup the filter select field picks the offset filter corner
// R5: the same field decides whether rate limiting applies after startup
// R6: with rate limiting the output moves at most one step per interval
// R7: self-test holds the offset output, also during startup
// R8: startup phase timers keep running through self-test
// R9: host should see startup done before it enables self-test; the bench first enables self-test during startup
// R10: offset monitoring starts 2.1 s after reset regardless of select field
// R11: filter output is compared against upper and lower offset limits
// R12: monitor counter counts up outside limits, down inside them
// R13: counter above threshold sets the offset fault in both status outputs
// R14: monitor counter saturates at its maximum and never wraps
// R15: output is linearly interpolated in sixteen sub-steps per sample
// R16: each result is delayed one sample before interpolation
// R17: a periodic data request returns an interpolated value, one sample late
// R18: the 26-bit value is clipped into 10, 14 and 16-bit words
// R19: short words feed periodic transfers, the 16-bit word the result registers
// R20: all widths share one LSB, the wider words only add range
// R21: enabled offset output is subtracted before interpolation and scaling
`timescale 1ns/1ps
`default_nettype none
module offset_chain #(
	parameter int unsigned PHASE1_CYCLES = offset_chain_pkg::PHASE1_CYC,
	parameter int unsigned PHASE2_CYCLES = offset_chain_pkg::PHASE2_CYC,
	parameter int unsigned MON_DELAY_CYCLES = offset_chain_pkg::MON_DELAY_CYC,
	parameter int unsigned RATE_STEP_INTERVAL = offset_chain_pkg::RATE_INTERVAL_CYC,
	parameter int unsigned RATE_STEP_SIZE = offset_chain_pkg::RATE_STEP_DEF,
	parameter int unsigned MON_CNT_W = offset_chain_pkg::MON_CNT_W_DEF,
	parameter int unsigned MONITOR_COUNT_THRESHOLD = offset_chain_pkg::MON_THRESHOLD_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// acceleration samples from the dsp chain
	input wire logic sampleValid,
	input wire logic signed [offset_chain_pkg::SAMPLE_W-1:0] accelSample,
	// configuration
	input wire logic offsetCancelEn,
	input wire logic [2:0] offsetFilterSelect,
	input wire logic selfTestActive,
	input wire logic signed [offset_chain_pkg::SAMPLE_W-1:0] offsetLimitHigh,
	input wire logic signed [offset_chain_pkg::SAMPLE_W-1:0] offsetLimitLow,
	// periodic data request
	input wire logic pdcmRequest,
	output logic pdcmValid,
	output logic [offset_chain_pkg::PDCM_SHORT_W-1:0] pdcmDataShort,
	output logic [offset_chain_pkg::PDCM_LONG_W-1:0] pdcmDataLong,
	// result registers
	output logic [7:0] accelResultHigh,
	output logic [7:0] accelResultLow,
	// status
	output logic offsetStartupDoneFlag,
	output logic accelStatusOffsetFault,
	output logic deviceStatusOffsetFault
);
	localparam int unsigned SW = offset_chain_pkg::SAMPLE_W;
	localparam int unsigned AW = offset_chain_pkg::ACC_W;
	localparam int unsigned FW = offset_chain_pkg::FRAC_W;
	localparam logic [MON_CNT_W-1:0] MONITOR_COUNT_MAX = '1;

	// ****************************************
	// saturation into a narrower signed word
	// ****************************************
	// symmetric range leaves the most negative code unused
	function automatic logic [15:0] clipTo(input logic signed [SW:0] v, input int unsigned w);
		logic signed [SW:0] lim;
		lim = (SW+1)'((64'sd1 <<< (w - 1)) - 64'sd1);
		if (v > lim) begin
			clipTo = 16'(lim);
		end else if (v < -lim) begin
			clipTo = 16'(-lim);
		end else begin
			clipTo = 16'(v);
		end
	endfunction : clipTo

	// ****************************************
	// startup phases
	// ****************************************
	offset_chain_pkg::startup_t phase_q;
	logic [31:0] phaseCnt_q;
	wire phaseEnd = (phase_q == offset_chain_pkg::PH_FAST) ? (phaseCnt_q == PHASE1_CYCLES - 1)
		: (phaseCnt_q == PHASE2_CYCLES - 1);

	// timer is blind to self-test
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= offset_chain_pkg::PH_FAST;
			phaseCnt_q <= 32'h0;
		end else if (phase_q != offset_chain_pkg::PH_DONE) begin
			phaseCnt_q <= phaseEnd ? 32'h0 : phaseCnt_q + 32'h1; // R8
			if (phaseEnd) begin
				case (phase_q)
					offset_chain_pkg::PH_FAST: phase_q <= offset_chain_pkg::PH_SLOW; // R3
					offset_chain_pkg::PH_SLOW: phase_q <= offset_chain_pkg::PH_DONE; // R3
					default: phase_q <= offset_chain_pkg::PH_DONE;
				endcase
			end
		end
	end
	wire startupDone = (phase_q == offset_chain_pkg::PH_DONE);
	assign offsetStartupDoneFlag = startupDone;

	// ****************************************
	// offset low-pass filter
	// ****************************************
	wire [1:0] corner = offsetFilterSelect[1:0];
	wire [offset_chain_pkg::GAIN_W-1:0] gain =
		(phase_q == offset_chain_pkg::PH_FAST) ? offset_chain_pkg::GAIN_10HZ : // R3
		(phase_q == offset_chain_pkg::PH_SLOW) ? offset_chain_pkg::GAIN_1HZ :
		(corner == offset_chain_pkg::SEL_CORNER_10HZ) ? offset_chain_pkg::GAIN_10HZ : // R4
		(corner == offset_chain_pkg::SEL_CORNER_1HZ) ? offset_chain_pkg::GAIN_1HZ :
		offset_chain_pkg::GAIN_0P1HZ;
	wire rateActive = startupDone && offsetFilterSelect[offset_chain_pkg::SEL_RATE_BIT]; // R5
	wire filtUpdate = sampleValid && !selfTestActive; // R7

	logic signed [AW-1:0] filtAcc_q;
	logic signed [SW-1:0] xPrev_q;
	wire signed [SW:0] xPair = {accelSample[SW-1], accelSample} + {xPrev_q[SW-1], xPrev_q};
	wire signed [SW-1:0] xAvg = xPair[SW:1];
	wire signed [AW:0] filtErr = {xAvg[SW-1], xAvg, {FW{1'b0}}} - {filtAcc_q[AW-1], filtAcc_q};
	wire signed [AW+offset_chain_pkg::GAIN_W+1:0] filtProd = filtErr * $signed({1'b0, gain});
	wire signed [AW-1:0] filtAcc_d = filtAcc_q + filtProd[AW+FW-1:FW]; // R2
	wire signed [SW-1:0] filtOut = filtAcc_q[AW-1:FW];
	wire signed [SW-1:0] filtOutNext = filtAcc_d[AW-1:FW];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			filtAcc_q <= '0;
			xPrev_q <= '0;
		end else if (filtUpdate) begin
			filtAcc_q <= filtAcc_d; // R2
			xPrev_q <= accelSample;
		end
	end

	// ****************************************
	// rate limiter and offset output
	// ****************************************
	// step toward the filter output, never past it
	logic [31:0] rateCnt_q;
	wire rateTick = (rateCnt_q == RATE_STEP_INTERVAL - 1);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rateCnt_q <= 32'h0;
		end else begin
			rateCnt_q <= rateTick ? 32'h0 : rateCnt_q + 32'h1;
		end
	end

	logic signed [SW-1:0] ocOut_q;
	wire signed [SW:0] ocDelta = {filtOut[SW-1], filtOut} - {ocOut_q[SW-1], ocOut_q};
	wire signed [SW:0] stepSize = (SW+1)'(RATE_STEP_SIZE);
	wire signed [SW-1:0] ocStepped = (ocDelta > stepSize) ? ocOut_q + SW'(RATE_STEP_SIZE)
		: (ocDelta < -stepSize) ? ocOut_q - SW'(RATE_STEP_SIZE) : filtOut; // R6
	wire ocStep = rateActive && rateTick;
	wire ocTrack = !rateActive && filtUpdate;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ocOut_q <= '0;
		end else if (!selfTestActive) begin // R7
			if (ocStep) begin
				ocOut_q <= ocStepped; // R6
			end else if (ocTrack) begin
				ocOut_q <= filtOutNext; // R3
			end
		end
	end

	// ****************************************
	// offset monitor
	// ****************************************
	logic [31:0] monDelay_q;
	logic monEnable_q;
	logic [MON_CNT_W-1:0] monCnt_q;
	logic fault_q;
	// counter floors at zero and rails at its top
	wire monOutside = (filtOut > offsetLimitHigh) || (filtOut < offsetLimitLow); // R11
	wire monSample = monEnable_q && sampleValid;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			monDelay_q <= 32'h0;
			monEnable_q <= 1'b0;
		end else if (!monEnable_q) begin
			monDelay_q <= monDelay_q + 32'h1;
			monEnable_q <= (monDelay_q == MON_DELAY_CYCLES - 1); // R10
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			monCnt_q <= '0;
		end else if (monSample) begin
			if (monOutside && monCnt_q != MONITOR_COUNT_MAX) begin // R14
				monCnt_q <= monCnt_q + 1'b1; // R12
			end else if (!monOutside && monCnt_q != '0) begin
				monCnt_q <= monCnt_q - 1'b1; // R12
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
		end else if (monCnt_q > MON_CNT_W'(MONITOR_COUNT_THRESHOLD)) begin
			fault_q <= 1'b1; // R13
		end
	end
	assign accelStatusOffsetFault = fault_q; // R13
	assign deviceStatusOffsetFault = fault_q; // R13

	// ****************************************
	// offset removal and one-sample delay
	// ****************************************
	wire signed [SW:0] corrected = offsetCancelEn
		? {accelSample[SW-1], accelSample} - {ocOut_q[SW-1], ocOut_q} // R21
		: {accelSample[SW-1], accelSample}; // R1
	logic signed [SW:0] curr_q;
	logic signed [SW:0] prev_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			curr_q <= '0;
			prev_q <= '0;
		end else if (sampleValid) begin
			curr_q <= corrected;
			prev_q <= curr_q; // R16
		end
	end

	// ****************************************
	// sixteen-step interpolation
	// ****************************************
	// sub-step stays at fifteen until the next sample
	logic [7:0] subDiv_q;
	logic [4:0] subStep_q;
	wire subTick = (subDiv_q == 8'(offset_chain_pkg::SUBSTEP_CYC - 1));
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			subDiv_q <= 8'h00;
			subStep_q <= 5'h00;
		end else if (sampleValid) begin
			subDiv_q <= 8'h00;
			subStep_q <= 5'h00;
		end else begin
			subDiv_q <= subTick ? 8'h00 : subDiv_q + 8'h01;
			if (subTick && subStep_q != 5'(offset_chain_pkg::SUBSTEPS - 1)) begin
				subStep_q <= subStep_q + 5'h01; // R15
			end
		end
	end
	wire signed [SW+1:0] interpSpan = {curr_q[SW], curr_q} - {prev_q[SW], prev_q};
	wire signed [SW+7:0] interpProd = interpSpan * $signed({1'b0, subStep_q});
	wire signed [SW:0] interpVal = prev_q + (SW+1)'(interpProd >>> 4); // R15

	// ****************************************
	// output scaling
	// ****************************************
	wire [15:0] clipShort = clipTo(interpVal, offset_chain_pkg::PDCM_SHORT_W); // R18
	wire [15:0] clipLong = clipTo(interpVal, offset_chain_pkg::PDCM_LONG_W); // R18
	wire [15:0] clipResult = clipTo(curr_q, offset_chain_pkg::RESULT_W) ^ offset_chain_pkg::RESULT_BIAS;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pdcmValid <= 1'b0;
			pdcmDataShort <= '0;
			pdcmDataLong <= '0;
		end else begin
			pdcmValid <= pdcmRequest; // R17
			if (pdcmRequest) begin
				pdcmDataShort <= clipShort[offset_chain_pkg::PDCM_SHORT_W-1:0]; // R19
				pdcmDataLong <= clipLong[offset_chain_pkg::PDCM_LONG_W-1:0]; // R20
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accelResultHigh <= offset_chain_pkg::RESULT_BIAS[15:8];
			accelResultLow <= offset_chain_pkg::RESULT_BIAS[7:0];
		end else begin
			accelResultHigh <= clipResult[15:8]; // R19
			accelResultLow <= clipResult[7:0]; // R19
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// last cycle of each startup phase
	sequence fastEnd_s;
		phase_q == offset_chain_pkg::PH_FAST && phaseCnt_q == PHASE1_CYCLES - 1;
	endsequence
	sequence slowEnd_s;
		phase_q == offset_chain_pkg::PH_SLOW && phaseCnt_q == PHASE2_CYCLES - 1;
	endsequence

	phase_order_a: assert property (fastEnd_s |=> phase_q == offset_chain_pkg::PH_SLOW) // R3
		else $error("fast startup phase did not hand over");
	startup_done_a: assert property (slowEnd_s |=> offsetStartupDoneFlag) // R8
		else $error("startup done not raised after second phase");
	freeze_hold_a: assert property (selfTestActive |=> $stable(ocOut_q)) // R7
		else $error("offset output moved during self-test");
	bypass_track_a: assert property (!startupDone && filtUpdate |=> ocOut_q == filtOut) // R3
		else $error("startup offset output not following filter");
	rate_step_a: assert property (rateActive && !selfTestActive |=>
		(ocOut_q - $past(ocOut_q) <= $signed(SW'(RATE_STEP_SIZE)))
		&& ($past(ocOut_q) - ocOut_q <= $signed(SW'(RATE_STEP_SIZE)))) // R6
		else $error("rate limited offset moved too far");
	mon_idle_a: assert property (!monEnable_q |-> monCnt_q == '0) // R10
		else $error("monitor counted before enable");
	mon_sat_a: assert property (monSample && monOutside && monCnt_q == MONITOR_COUNT_MAX
		|=> monCnt_q == MONITOR_COUNT_MAX) // R14
		else $error("monitor counter wrapped");
	fault_set_a: assert property (monCnt_q > MON_CNT_W'(MONITOR_COUNT_THRESHOLD)
		|=> accelStatusOffsetFault && deviceStatusOffsetFault) // R13
		else $error("offset fault not raised above threshold");
	sample_delay_a: assert property (sampleValid |=> prev_q == $past(curr_q)) // R16
		else $error("previous sample not delayed by one");
	pdcm_answer_a: assert property (pdcmRequest |=> pdcmValid && pdcmDataShort == $past(clipShort[9:0])) // R17
		else $error("periodic request not answered next cycle");
	track_normal_a: assert property (startupDone && !rateActive && filtUpdate |=> ocOut_q == filtOut) // R5
		else $error("offset output not following filter without rate limit");
	mon_up_a: assert property (monSample && monOutside && monCnt_q != MONITOR_COUNT_MAX
		|=> monCnt_q == $past(monCnt_q) + 1'b1) // R12
		else $error("monitor counter did not count up");
	mon_down_a: assert property (monSample && !monOutside && monCnt_q != '0
		|=> monCnt_q == $past(monCnt_q) - 1'b1) // R12
		else $error("monitor counter did not count down");
	fault_sticky_a: assert property (accelStatusOffsetFault |=> accelStatusOffsetFault) // R13
		else $error("offset fault cleared without reset");
	short_clip_a: assert property (pdcmValid |-> pdcmDataShort != 10'h200) // R18
		else $error("short word not clipped");
	long_clip_a: assert property (pdcmValid |-> pdcmDataLong != 14'h2000) // R18
		else $error("long word not clipped");
	result_clip_a: assert property ({accelResultHigh, accelResultLow} != 16'h0000) // R18
		else $error("result word not clipped");
endmodule : offset_chain
`default_nettype wire

// ### test/pdcm_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdcm_master_model (
	// clock
	input wire logic clk_sys,
	// periodic data request and its answer
	output logic pdcmRequest,
	input wire logic pdcmValid,
	input wire logic [offset_chain_pkg::PDCM_SHORT_W-1:0] pdcmDataShort,
	input wire logic [offset_chain_pkg::PDCM_LONG_W-1:0] pdcmDataLong
);
	initial pdcmRequest = 1'b0;

	// ****************************************
	// one request pulse, answer taken in the cycle after the taking edge
	// ****************************************
	task automatic poll(
		output logic gotValid,
		output logic [offset_chain_pkg::PDCM_SHORT_W-1:0] shortWord,
		output logic [offset_chain_pkg::PDCM_LONG_W-1:0] longWord
	);
		@(negedge clk_sys);
		pdcmRequest = 1'b1;
		@(negedge clk_sys);
		gotValid = pdcmValid;
		shortWord = pdcmDataShort;
		longWord = pdcmDataLong;
		pdcmRequest = 1'b0;
	endtask : poll
endmodule : pdcm_master_model
`default_nettype wire

// ### test/offset_chain_bench.sv
`timescale 1ns/1ps
`default_nettype none
module offset_chain_bench;
	// ****************************************
	// signals
	// ****************************************
	localparam int unsigned THRESHOLD = 100;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic sampleValid = 1'b0;
	logic signed [25:0] accelSample = 26'h0000000;
	logic offsetCancelEn = 1'b1;
	logic [2:0] offsetFilterSelect = 3'h0;
	logic selfTestActive = 1'b0;
	logic signed [25:0] offsetLimitHigh = 26'h0000064;
	logic signed [25:0] offsetLimitLow = 26'h3FFFF9C;
	wire logic pdcmRequest;
	wire logic pdcmValid;
	wire logic [9:0] pdcmDataShort;
	wire logic [13:0] pdcmDataLong;
	wire logic [7:0] accelResultHigh;
	wire logic [7:0] accelResultLow;
	wire logic offsetStartupDoneFlag;
	wire logic accelStatusOffsetFault;
	wire logic deviceStatusOffsetFault;
	logic [15:0] resultWord;
	int cyc = 0;
	int bad_count = 0;
	int num_checks = 0;
	logic gotValid;
	logic [9:0] gotShort;
	logic [13:0] gotLong;
	logic [15:0] ra;
	logic [15:0] rb;

	assign resultWord = {accelResultHigh, accelResultLow};
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (!rst_n) cyc <= 0;
		else cyc <= cyc + 1;
	end

	offset_chain #(
		.PHASE1_CYCLES(200),
		.PHASE2_CYCLES(150),
		.MON_DELAY_CYCLES(2000),
		.RATE_STEP_INTERVAL(20),
		.MONITOR_COUNT_THRESHOLD(THRESHOLD)
	) uut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.sampleValid(sampleValid),
		.accelSample(accelSample),
		.offsetCancelEn(offsetCancelEn),
		.offsetFilterSelect(offsetFilterSelect),
		.selfTestActive(selfTestActive),
		.offsetLimitHigh(offsetLimitHigh),
		.offsetLimitLow(offsetLimitLow),
		.pdcmRequest(pdcmRequest),
		.pdcmValid(pdcmValid),
		.pdcmDataShort(pdcmDataShort),
		.pdcmDataLong(pdcmDataLong),
		.accelResultHigh(accelResultHigh),
		.accelResultLow(accelResultLow),
		.offsetStartupDoneFlag(offsetStartupDoneFlag),
		.accelStatusOffsetFault(accelStatusOffsetFault),
		.deviceStatusOffsetFault(deviceStatusOffsetFault)
	);

	pdcm_master_model master (
		.clk_sys(clk_sys),
		.pdcmRequest(pdcmRequest),
		.pdcmValid(pdcmValid),
		.pdcmDataShort(pdcmDataShort),
		.pdcmDataLong(pdcmDataLong)
	);

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic send(input logic signed [25:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			sampleValid = 1'b1;
			accelSample = v;
			@(negedge clk_sys);
			sampleValid = 1'b0;
		end
	endtask : send

	task automatic wait_until(input int n);
		for (int i = 0; i < 5000 && cyc < n; i++) @(negedge clk_sys);
		if (cyc < n) begin
			bad_count++;
			tally_and_finish();
		end
	endtask : wait_until

	task automatic faults(input logic exp);
		chk("accel fault", {31'h0, exp}, {31'h0, accelStatusOffsetFault});
		chk("device fault", {31'h0, exp}, {31'h0, deviceStatusOffsetFault});
	endtask : faults

	task automatic tally_and_finish();
		if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (10000) @(posedge clk_sys);
		bad_count++;
		tally_and_finish();
	end

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clk_sys);
		chk("reset result", 32'h8000, {16'h0, resultWord});
		chk("reset flags", 32'h0, {29'h0, offsetStartupDoneFlag, accelStatusOffsetFault,
			pdcmValid});
		repeat (1) @(negedge clk_sys);
		rst_n = 1'b1;
		send(26'h0000FA0, 40);
		chk("offset removed", 32'h1, {31'h0, (resultWord > 16'h8000) && (resultWord < 16'h8FA0)});
		selfTestActive = 1'b1;
		send(26'h0000FA0, 2);
		ra = resultWord;
		send(26'h0000FA0, 40);
		chk("self-test hold", {16'h0, ra}, {16'h0, resultWord});
		wait_until(340);
		chk("startup early", 32'h0, {31'h0, offsetStartupDoneFlag});
		wait_until(360);
		chk("startup done", 32'h1, {31'h0, offsetStartupDoneFlag});
		selfTestActive = 1'b0;
		send(26'h0000FA0, 100);
		wait_until(1990);
		faults(1'b0);
		wait_until(2010);
		send(26'h0000FA0, 50);
		offsetLimitHigh = 26'h0002710;
		send(26'h0000FA0, 50);
		offsetLimitHigh = 26'h0000064;
		send(26'h0000FA0, THRESHOLD);
		faults(1'b0);
		send(26'h0000FA0, 1);
		repeat (2) @(negedge clk_sys);
		faults(1'b1);
		offsetFilterSelect = 3'h4;
		send(26'h0004E20, 5);
		ra = resultWord;
		send(26'h0004E20, 50);
		rb = resultWord;
		chk("rate bound", 32'h1, {31'h0, (rb >= ra - 16'h0006) && (rb <= ra + 16'h0006)});
		offsetFilterSelect = 3'h0;
		send(26'h0004E20, 5);
		ra = resultWord;
		send(26'h0004E20, 50);
		rb = resultWord;
		chk("rate off", 32'h1, {31'h0, ra > rb + 16'h0064});
		offsetCancelEn = 1'b0;
		send(26'h0000000, 1);
		send(26'h0000640, 1);
		@(negedge clk_sys);
		chk("latest result", 32'h8640, {16'h0, resultWord});
		master.poll(gotValid, gotShort, gotLong);
		chk("pdcm valid", 32'h1, {31'h0, gotValid});
		chk("pdcm prev long", 32'h0, {18'h0, gotLong});
		repeat (80) @(negedge clk_sys);
		master.poll(gotValid, gotShort, gotLong);
		chk("interp short", 32'h1FF, {22'h0, gotShort});
		chk("interp long", 32'h320, {18'h0, gotLong});
		send(26'h0100000, 1);
		@(negedge clk_sys);
		chk("clip high", 32'hFFFF, {16'h0, resultWord});
		send(26'h3F00000, 1);
		@(negedge clk_sys);
		chk("clip low", 32'h0001, {16'h0, resultWord});
		send(26'h0000000, 1);
		master.poll(gotValid, gotShort, gotLong);
		chk("short low", 32'h201, {22'h0, gotShort});
		chk("long low", 32'h2001, {18'h0, gotLong});
		chk("startup before test", 32'h1, {31'h0, offsetStartupDoneFlag});
		selfTestActive = 1'b1;
		tally_and_finish();
	end
endmodule : offset_chain_bench
`default_nettype wire
